// *** rtl/byte_counter_core.sv ***
// Thirty-two bit transfer counter with byte-lane load, clear and up/down step
`timescale 1ns/100ps
`include "dma_count_map.svh"

module byte_counter_core (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [3:0] lane_wr_i,
    input wire logic [7:0] lane_data_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic count_up_i,
    output logic [31:0] count_o,
    output logic wrap_o,
    output logic last_o
);

    logic [31:0] count_q; // Counter value
    logic [31:0] count_d; // Next counter value
    logic [31:0] loaded; // Value after byte-lane loads

    // Each lane takes the write data or keeps its byte
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign loaded[lane*8 +: 8] = lane_wr_i[lane] ? lane_data_i : count_q[lane*8 +: 8];
        end
    endgenerate

    // Clear first, then loads, then counting; the top never mixes loads and steps
    always_comb begin
        if (clear_i) begin
            count_d = `RESET_COUNT;
        end else if (|lane_wr_i) begin
            count_d = loaded;
        end else if (step_i && count_up_i) begin
            count_d = count_q + `COUNT_ONE; // wraps to zero
        end else if (step_i) begin
            count_d = count_q - `COUNT_ONE;
        end else begin
            count_d = count_q;
        end
    end

    // Counter register, zero after reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_q <= `RESET_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_o = count_q;
    // Overflow event: a step up from all ones
    assign wrap_o = step_i & count_up_i & (count_q == `COUNT_ALL_ONES);
    // Final byte of a count-mode transfer
    assign last_o = step_i & ~count_up_i & (count_q == `COUNT_ONE);

endmodule : byte_counter_core

// *** rtl/dma_channel_byte_counter.sv ***
// Byte accounting of one DMA channel: FIFO remain indicator and transfer counter
`timescale 1ns/100ps
`include "dma_count_map.svh"

module dma_channel_byte_counter (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire dma_count_pkg::reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire dma_count_pkg::fifo_status_t fifo_status_i,
    input wire logic byte_move_i,
    output logic running_o,
    output logic free_running_mode_o,
    output logic transfer_end_o,
    output logic [31:0] byte_count_o,
    output logic irq_o
);

    // Address decode
    wire hit_config; // Mode register
    wire hit_control; // Start, stop, clear and running
    wire hit_remain_high; // Remain bits 11 to 8
    wire hit_remain_low; // Remain bits 7 to 0
    wire hit_count3; // Counter bits 31 to 24
    wire hit_count2; // Counter bits 23 to 16
    wire hit_count1; // Counter bits 15 to 8
    wire hit_count0; // Counter bits 7 to 0
    wire hit_status; // Interrupt status
    wire hit_mask; // Interrupt mask

    assign hit_config = reg_req_i.addr == `ADDR_CONFIG;
    assign hit_control = reg_req_i.addr == `ADDR_CONTROL;
    assign hit_remain_high = reg_req_i.addr == `ADDR_REMAIN_HIGH;
    assign hit_remain_low = reg_req_i.addr == `ADDR_REMAIN_LOW;
    assign hit_count3 = reg_req_i.addr == `ADDR_COUNT_BYTE3;
    assign hit_count2 = reg_req_i.addr == `ADDR_COUNT_BYTE2;
    assign hit_count1 = reg_req_i.addr == `ADDR_COUNT_BYTE1;
    assign hit_count0 = reg_req_i.addr == `ADDR_COUNT_BYTE0;
    assign hit_status = reg_req_i.addr == `ADDR_INT_STATUS;
    assign hit_mask = reg_req_i.addr == `ADDR_INT_MASK;

    // Registered state
    dma_count_pkg::chan_state_t state_q; // Transfer state
    dma_count_pkg::chan_state_t state_d; // Next transfer state
    logic running_q; // Running status as seen by software
    logic free_run_q; // Free-running mode select
    logic [1:0] int_status_q; // Sticky event flags
    logic [1:0] int_status_d; // Next event flags
    logic [1:0] int_mask_q; // Interrupt enables
    logic irq_q; // Interrupt output
    logic end_q; // One-cycle end-of-transfer pulse
    logic [11:0] remain_q; // Sampled remain value
    logic [7:0] remain_snap_q; // Remain low byte held for the second read
    logic [23:0] count_snap_q; // Counter low bytes held for the later reads
    logic [7:0] rdata_q; // Read data register

    // Counter core connections
    logic [31:0] count; // Current counter value
    logic count_wrap; // Overflow in free-running mode
    logic count_last; // Last byte in count mode
    wire [3:0] lane_wr; // Byte-lane load strobes
    wire count_clear; // Counter clear strobe
    wire count_step; // One byte moved while running

    // Write strobes
    wire wr_config;
    wire wr_control;
    wire wr_status;
    wire wr_mask;

    assign wr_config = reg_req_i.wr & hit_config;
    assign wr_control = reg_req_i.wr & hit_control;
    assign wr_status = reg_req_i.wr & hit_status;
    assign wr_mask = reg_req_i.wr & hit_mask;

    // Control commands; start only from idle, stop only while running
    wire start_req;
    wire stop_req;
    wire clear_req;

    assign start_req = wr_control & reg_req_i.wdata[`CTRL_START_BIT] & ~running_q;
    assign stop_req = wr_control & reg_req_i.wdata[`CTRL_STOP_BIT] & running_q;
    // A clear during a transfer is dropped without trace
    assign clear_req = wr_control & reg_req_i.wdata[`CTRL_CLEAR_BIT] & ~running_q;

    // Counter loads are refused while running; mid-transfer loads would
    // break the end-of-count decision and gain nothing
    assign lane_wr[3] = reg_req_i.wr & hit_count3 & ~running_q;
    assign lane_wr[2] = reg_req_i.wr & hit_count2 & ~running_q;
    assign lane_wr[1] = reg_req_i.wr & hit_count1 & ~running_q;
    assign lane_wr[0] = reg_req_i.wr & hit_count0 & ~running_q;
    assign count_clear = clear_req;
    // Bytes count only while the channel is running
    assign count_step = byte_move_i & (state_q == dma_count_pkg::CH_RUN);

    // Transfer counter
    byte_counter_core u_counter (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .lane_wr_i(lane_wr),
        .lane_data_i(reg_req_i.wdata),
        .clear_i(count_clear),
        .step_i(count_step),
        .count_up_i(free_run_q),
        .count_o(count),
        .wrap_o(count_wrap),
        .last_o(count_last)
    );

    // Start in count mode with nothing to move ends at once
    wire zero_start;
    wire run_end;
    wire end_event;

    assign zero_start = start_req & ~free_run_q & (count == `RESET_COUNT);
    // Free-running transfers end only by stop; overflow does not end them
    assign run_end = (state_q == dma_count_pkg::CH_RUN) & (stop_req | count_last);
    assign end_event = run_end | zero_start;

    // Transfer state
    always_comb begin
        case (state_q)
            dma_count_pkg::CH_IDLE: begin
                // The count loaded before start is the one used
                if (start_req && !zero_start) begin
                    state_d = dma_count_pkg::CH_RUN;
                end else begin
                    state_d = dma_count_pkg::CH_IDLE;
                end
            end
            dma_count_pkg::CH_RUN: begin
                // Stop or last byte return to idle
                if (run_end) begin
                    state_d = dma_count_pkg::CH_IDLE;
                end else begin
                    state_d = dma_count_pkg::CH_RUN;
                end
            end
            default: begin
                state_d = dma_count_pkg::CH_IDLE;
            end
        endcase
    end

    // State, running status and end pulse
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= dma_count_pkg::CH_IDLE;
            running_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            state_q <= state_d;
            running_q <= state_d == dma_count_pkg::CH_RUN;
            end_q <= end_event;
        end
    end

    // Mode register; a mode change mid-transfer is allowed but unwise
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            free_run_q <= 1'b0;
        end else if (wr_config) begin
            free_run_q <= reg_req_i.wdata[`CFG_FREE_RUN_BIT];
        end
    end

    // Event flags: a new event wins over a write-one clear in the same cycle
    wire [1:0] int_set;
    wire [1:0] int_clr;

    assign int_set[`INT_COMPLETE_BIT] = end_event;
    assign int_set[`INT_OVERFLOW_BIT] = count_wrap;
    assign int_clr = wr_status ? reg_req_i.wdata[1:0] : `RESET_FLAGS;

    always_comb begin
        int_status_d = (int_status_q & ~int_clr) | int_set;
    end

    // Flags, mask and interrupt line
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            int_status_q <= `RESET_FLAGS;
            int_mask_q <= `RESET_FLAGS;
            irq_q <= 1'b0;
        end else begin
            int_status_q <= int_status_d;
            if (wr_mask) begin
                int_mask_q <= reg_req_i.wdata[1:0];
            end
            // Follows the flags one cycle later
            irq_q <= |(int_status_q & int_mask_q);
        end
    end

    // Remain source: data count when read-joined, free space when write-joined
    wire [11:0] remain_live;

    assign remain_live = fifo_status_i.endpoint_join_read ? fifo_status_i.data_count :
                         fifo_status_i.endpoint_join_write ? fifo_status_i.free_space :
                         `RESET_REMAIN;

    // Sampling the remain value costs one cycle, which is why software
    // must leave a gap after a channel write before looking at it
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            remain_q <= `RESET_REMAIN;
        end else begin
            remain_q <= remain_live;
        end
    end

    // Snapshots taken on the most significant byte read
    wire rd_remain_high;
    wire rd_count3;

    assign rd_remain_high = reg_req_i.rd & hit_remain_high;
    assign rd_count3 = reg_req_i.rd & hit_count3;

    // Lower bytes are returned from the snapshot so a multi-byte read is
    // coherent; reading them out of order returns a stale snapshot
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            remain_snap_q <= `RESET_BYTE;
            count_snap_q <= `RESET_SNAP;
        end else begin
            if (rd_remain_high) begin
                remain_snap_q <= remain_q[7:0];
            end
            if (rd_count3) begin
                count_snap_q <= count[23:0];
            end
        end
    end

    // Read data select; write-only control bits read as zero
    wire [7:0] rd_config;
    wire [7:0] rd_control;
    wire [7:0] rd_remain_h;
    wire [7:0] rd_status;
    wire [7:0] rd_mask;
    wire [7:0] rd_sel;

    assign rd_config = {free_run_q, `ZERO_7};
    assign rd_control = {running_q, `ZERO_7};
    // Upper four bits of the remain high byte are always zero
    assign rd_remain_h = {`REMAIN_PAD, remain_q[11:8]};
    assign rd_status = {`ZERO_6, int_status_q};
    assign rd_mask = {`ZERO_6, int_mask_q};

    // Counter bytes read the live value on the top byte, the snapshot below
    assign rd_sel = hit_config ? rd_config :
                    hit_control ? rd_control :
                    hit_remain_high ? rd_remain_h :
                    hit_remain_low ? remain_snap_q :
                    hit_count3 ? count[31:24] :
                    hit_count2 ? count_snap_q[23:16] :
                    hit_count1 ? count_snap_q[15:8] :
                    hit_count0 ? count_snap_q[7:0] :
                    hit_status ? rd_status :
                    hit_mask ? rd_mask :
                    `RESET_BYTE;

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= `RESET_BYTE;
        end else if (reg_req_i.rd) begin
            rdata_q <= rd_sel;
        end else begin
            rdata_q <= `RESET_BYTE;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o = rdata_q;
    assign running_o = running_q;
    assign free_running_mode_o = free_run_q;
    assign transfer_end_o = end_q;
    assign byte_count_o = count;
    assign irq_o = irq_q;

endmodule : dma_channel_byte_counter

// *** rtl/dma_count_map.svh ***
// Register offsets, field positions and reset values of the byte counter block
`ifndef DMA_COUNT_MAP_SVH
`define DMA_COUNT_MAP_SVH

// Byte-wide register offsets
`define ADDR_CONFIG 8'h81
`define ADDR_CONTROL 8'h82
`define ADDR_REMAIN_HIGH 8'h84
`define ADDR_REMAIN_LOW 8'h85
`define ADDR_COUNT_BYTE3 8'h88
`define ADDR_COUNT_BYTE2 8'h89
`define ADDR_COUNT_BYTE1 8'h8A
`define ADDR_COUNT_BYTE0 8'h8B
`define ADDR_INT_STATUS 8'hA0
`define ADDR_INT_MASK 8'hA1

// Field positions
`define CFG_FREE_RUN_BIT 7
`define CTRL_RUNNING_BIT 7
`define CTRL_CLEAR_BIT 4
`define CTRL_STOP_BIT 1
`define CTRL_START_BIT 0
`define INT_COMPLETE_BIT 0
`define INT_OVERFLOW_BIT 1

// Reset and fixed values
`define RESET_BYTE 8'h00
`define RESET_FLAGS 2'h0
`define RESET_COUNT 32'h0000_0000
`define RESET_REMAIN 12'h000
`define RESET_SNAP 24'h00_0000
`define COUNT_ONE 32'h0000_0001
`define COUNT_ALL_ONES 32'hFFFF_FFFF
`define REMAIN_PAD 4'h0
`define ZERO_7 7'h00
`define ZERO_6 6'h00

`endif

// *** rtl/dma_count_pkg.sv ***
// Types shared by the byte counter block
package dma_count_pkg;

    // One register bus request, all fields from the same clock
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Status of the endpoint FIFO joined to the channel
    typedef struct packed {
        logic endpoint_join_read;
        logic endpoint_join_write;
        logic [11:0] data_count;
        logic [11:0] free_space;
    } fifo_status_t;

    // Channel transfer states
    typedef enum logic [0:0] {
        CH_IDLE,
        CH_RUN
    } chan_state_t;

endpackage : dma_count_pkg

// *** test/dma_channel_byte_counter_props.sv ***
// Port checker for the channel byte counter, bound to the design top
`timescale 1ns/100ps
`include "dma_count_map.svh"
module dma_channel_byte_counter_props (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire dma_count_pkg::reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire dma_count_pkg::fifo_status_t fifo_status_i,
    input wire logic byte_move_i,
    input wire logic running_o,
    input wire logic free_running_mode_o,
    input wire logic transfer_end_o,
    input wire logic [31:0] byte_count_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    // A counted byte; a racing write is left out, though counter loads are refused while running
    sequence s_step;
        running_o && byte_move_i && !reg_req_i.wr;
    endsequence
    // Host write to the control register
    sequence s_ctrl;
        reg_req_i.wr && reg_req_i.addr == `ADDR_CONTROL;
    endsequence
    property p_pad;
        reg_req_i.rd && reg_req_i.addr == `ADDR_REMAIN_HIGH |=> reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_pad: assert property (p_pad) else $error("remain pad not zero");
    property p_down;
        s_step ##0 (!free_running_mode_o && byte_count_o != 32'h0)
            |=> byte_count_o == $past(byte_count_o) - 32'h1;
    endproperty
    a_down: assert property (p_down) else $error("count mode step wrong");
    property p_up;
        s_step ##0 free_running_mode_o |=> byte_count_o == $past(byte_count_o) + 32'h1;
    endproperty
    a_up: assert property (p_up) else $error("free run step wrong");
    property p_wrap;
        s_step ##0 (free_running_mode_o && byte_count_o == `COUNT_ALL_ONES)
            |=> running_o && byte_count_o == 32'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap stopped or missed");
    property p_last;
        s_step ##0 (!free_running_mode_o && byte_count_o == `COUNT_ONE)
            |=> !running_o ##[0:1] transfer_end_o;
    endproperty
    a_last: assert property (p_last) else $error("no end after last byte");
    property p_idle;
        !running_o && !reg_req_i.wr |=> $stable(byte_count_o);
    endproperty
    a_idle: assert property (p_idle) else $error("idle counter moved");
    property p_clr_busy;
        running_o ##0 s_ctrl ##0 (reg_req_i.wdata[`CTRL_CLEAR_BIT] && !byte_move_i)
            |=> $stable(byte_count_o);
    endproperty
    a_clr_busy: assert property (p_clr_busy) else $error("clear taken while running");
    property p_clr;
        !running_o ##0 s_ctrl ##0 (reg_req_i.wdata[`CTRL_CLEAR_BIT]
            && !reg_req_i.wdata[`CTRL_START_BIT]) |=> byte_count_o == `RESET_COUNT;
    endproperty
    a_clr: assert property (p_clr) else $error("clear not taken");
    property p_stop;
        running_o ##0 s_ctrl ##0 reg_req_i.wdata[`CTRL_STOP_BIT]
            |=> !running_o ##[0:1] transfer_end_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_go;
        !running_o ##0 s_ctrl ##0 (reg_req_i.wdata[1:0] == 2'h1 && !reg_req_i.wdata[4]
            && (free_running_mode_o || byte_count_o != 32'h0)) |=> running_o;
    endproperty
    a_go: assert property (p_go) else $error("start not taken");
endmodule : dma_channel_byte_counter_props

bind dma_channel_byte_counter dma_channel_byte_counter_props props_u (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .fifo_status_i(fifo_status_i), .byte_move_i(byte_move_i), .running_o(running_o),
    .free_running_mode_o(free_running_mode_o), .transfer_end_o(transfer_end_o),
    .byte_count_o(byte_count_o), .irq_o(irq_o));

// *** test/dma_channel_byte_counter_test.sv ***
// Self-checking bench for the channel byte counter
`timescale 1ns/100ps
`include "dma_count_map.svh"
module dma_channel_byte_counter_test;
    logic clk_sys_i = 1'b0; // 20 MHz system clock
    logic nrst_i = 1'b0; // Reset, active low
    dma_count_pkg::reg_req_t reg_req; // Driven by the host model
    dma_count_pkg::fifo_status_t fifo_st = '0; // Endpoint FIFO side
    logic byte_move_i = 1'b0; // One pulse per moved byte
    logic [7:0] rdata;
    logic running, free_mode, xfer_end, irq;
    logic [31:0] count;
    int errors = 0;
    int tests_run = 0;
    int seed = 32'h1d14;
    int ends = 0; // End pulses seen
    logic [31:0] exp_cnt = '0; // Counter model
    logic [31:0] val;
    logic [7:0] b;

    always #25 clk_sys_i = ~clk_sys_i;

    dma_channel_byte_counter dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_req_i(reg_req),
        .reg_rdata_o(rdata), .fifo_status_i(fifo_st), .byte_move_i(byte_move_i),
        .running_o(running), .free_running_mode_o(free_mode), .transfer_end_o(xfer_end),
        .byte_count_o(count), .irq_o(irq));
    host_cpu_model host_u (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_req_o(reg_req));

    // Count end pulses rather than guess which cycle carries them
    always @(posedge clk_sys_i) if (xfer_end === 1'b1) ends <= ends + 1;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd(a, b);
        check({24'h0, b}, {24'h0, exp});
    endtask : rd_chk

    // Counter bytes always go high byte first
    task wr_cnt(input logic [31:0] v);
        for (int i = 0; i < 4; i++) host_u.wr(8'(`ADDR_COUNT_BYTE3 + i), v[31 - 8 * i -: 8]);
    endtask : wr_cnt

    task rd_cnt;
        for (int i = 0; i < 4; i++) begin
            host_u.rd(8'(`ADDR_COUNT_BYTE3 + i), b);
            val = {val[23:0], b};
        end
    endtask : rd_cnt

    // FIFO changes between the two reads, so the low byte must come from the snapshot
    task remain_chk(input logic [11:0] exp);
        rd_chk(`ADDR_REMAIN_HIGH, {4'h0, exp[11:8]});
        fifo_st.data_count <= ~fifo_st.data_count;
        fifo_st.free_space <= ~fifo_st.free_space;
        repeat (3) @(posedge clk_sys_i);
        rd_chk(`ADDR_REMAIN_LOW, exp[7:0]);
    endtask : remain_chk

    // Moved bytes with random gaps, counter compared after each
    task move(input int n, input bit up);
        repeat (n) begin
            @(posedge clk_sys_i);
            byte_move_i <= 1'b1;
            @(posedge clk_sys_i);
            byte_move_i <= 1'b0;
            exp_cnt = up ? exp_cnt + 32'h1 : exp_cnt - 32'h1;
            #1 check(count, exp_cnt);
            repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys_i);
        end
    endtask : move

    task finish_test;
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Run is a few hundred cycles; this cuts a hang well after that
    initial begin
        #1_000_000;
        errors++;
        finish_test;
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) rd_chk(8'(`ADDR_REMAIN_HIGH + i), 8'h00);
        fifo_st <= '{1'b1, 1'b0, 12'($random(seed)), 12'($random(seed))};
        repeat (3) @(posedge clk_sys_i);
        remain_chk(fifo_st.data_count);
        fifo_st.endpoint_join_read <= 1'b0;
        fifo_st.endpoint_join_write <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        remain_chk(fifo_st.free_space);
        exp_cnt = $random(seed);
        wr_cnt(exp_cnt);
        rd_cnt;
        check(val, exp_cnt);
        // Count mode run to zero with the complete interrupt unmasked
        host_u.wr(`ADDR_INT_MASK, 8'h01);
        exp_cnt = 32'(3 + $unsigned($random(seed)) % 4);
        wr_cnt(exp_cnt);
        host_u.wr(`ADDR_CONTROL, 8'h01);
        #1 check({31'h0, running}, 32'h1);
        move(int'(exp_cnt), 1'b0);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, running}, 32'h0);
        check(ends, 1);
        check({31'h0, irq}, 32'h1);
        rd_chk(`ADDR_INT_STATUS, 8'h01);
        // Start with a zero count ends at once
        host_u.wr(`ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, running}, 32'h0);
        check(ends, 2);
        host_u.wr(`ADDR_INT_STATUS, 8'h01);
        host_u.wr(`ADDR_INT_MASK, 8'h00);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, irq}, 32'h0);
        // Free run across the wrap, then clear and reload refused while running
        host_u.wr(`ADDR_CONFIG, 8'h80);
        #1 check({31'h0, free_mode}, 32'h1);
        rd_chk(`ADDR_CONFIG, 8'h80);
        exp_cnt = 32'hFFFF_FFFE;
        wr_cnt(exp_cnt);
        host_u.wr(`ADDR_CONTROL, 8'h01);
        move(3, 1'b1);
        host_u.wr(`ADDR_CONTROL, 8'h10);
        wr_cnt(32'h0);
        rd_cnt;
        check(val, exp_cnt);
        check({31'h0, running}, 32'h1);
        rd_chk(`ADDR_CONTROL, 8'h80);
        check({31'h0, irq}, 32'h0);
        rd_chk(`ADDR_INT_STATUS, 8'h02);
        host_u.wr(`ADDR_INT_MASK, 8'h02);
        rd_chk(`ADDR_INT_MASK, 8'h02);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, irq}, 32'h1);
        host_u.wr(`ADDR_CONTROL, 8'h02);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, running}, 32'h0);
        rd_chk(`ADDR_CONTROL, 8'h00);
        check(ends, 3);
        rd_chk(`ADDR_INT_STATUS, 8'h03);
        host_u.wr(`ADDR_CONTROL, 8'h10);
        rd_cnt;
        check(val, 32'h0);
        host_u.wr(`ADDR_INT_STATUS, 8'h03);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, irq}, 32'h0);
        finish_test;
    end
endmodule : dma_channel_byte_counter_test

// *** test/host_cpu_model.sv ***
// Host processor model driving the byte-wide register port
`timescale 1ns/100ps
module host_cpu_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    output dma_count_pkg::reg_req_t reg_req_o
);
    // Idle from time zero so nothing is requested during reset
    initial reg_req_o = '0;
    // One-cycle write; lines are inverted after so stale values never look valid
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        reg_req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    // One-cycle read; the gap before it covers the settling cycle after a move
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_req_o <= '{addr: a, wdata: ~reg_req_o.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        reg_req_o <= '{addr: ~a, wdata: ~reg_req_o.wdata, wr: 1'b0, rd: 1'b0};
        // Data stand for the one cycle after the strobe; take them at its closing edge
        @(posedge clk_sys_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : host_cpu_model
